/* File: rtl/liu_global_control_regs.sv */
// Global control register bank with per-channel line data and loss-of-signal logic
`default_nettype none

module liu_global_control_regs (
    input  wire logic        clock,
    input  wire logic        srst,
    input  wire logic [6:0]  host_addr,
    input  wire logic [7:0]  host_wdata,
    input  wire logic        host_wr,
    input  wire logic        host_rd,
    output logic      [7:0]  host_rdata,
    input  wire logic [3:0]  tx_positive_in,
    input  wire logic [3:0]  tx_negative_in,
    input  wire logic [3:0]  rx_pos_in,
    input  wire logic [3:0]  rx_neg_in,
    input  wire logic [3:0]  rx_bit_valid,
    input  wire logic [3:0]  chan_irq_req,
    input  wire logic        arb_pulse_en,
    input  wire logic        ext_los_en,
    output logic      [3:0]  tx_pos_line,
    output logic      [3:0]  tx_neg_line,
    output logic      [3:0]  rx_pos_out,
    output logic      [3:0]  rx_neg_out,
    output logic      [3:0]  chan_irq,
    output logic      [3:0]  rx_loss_of_signal,
    output logic             rail_mode_select,
    output logic             auto_ones_on_los,
    output logic             rx_out_edge_select,
    output logic             tx_sample_edge_select,
    output logic             line_data_polarity,
    output logic             global_irq_enable,
    output logic             soft_reset_bit,
    output logic             core_reset,
    output logic      [2:0]  synth_source_select,
    output logic             synth_rate_select,
    output logic             synth_retune,
    output logic      [2:0]  pulse_segment,
    output logic      [27:0] pulse_amp
);
    // Segment register decode, shared by write and read paths
    function automatic logic seg_hit(input logic [6:0] a);
        return a == liu_pkg::OFS_SEG8_CH0 || a == liu_pkg::OFS_SEG8_CH1 ||
               a == liu_pkg::OFS_SEG8_CH2 || a == liu_pkg::OFS_SEG8_CH3;
    endfunction

    liu_seg_if seg ();
    liu_seg_mem u_seg (
        .clock (clock),
        .srst  (srst),
        .port  (seg.mem)
    );

    // ------------------------------------------------------------------
    // Host registers
    // ------------------------------------------------------------------
    logic [7:0] glob_q, glob_d, synth_q, synth_d, rdata_q, rdata_d;
    logic       rd_seg_q, rd_seg_d, retune_q, retune_d;

    assign seg.wr     = host_wr && seg_hit(host_addr);
    assign seg.wr_idx = host_addr[5:4];
    assign seg.wdata  = host_wdata[liu_pkg::AMP_W-1:0];  // [RULE17] bit 7 dropped
    assign seg.rd_idx = host_addr[5:4];

    // Writes, reads and retune detection
    always_comb begin
        glob_d   = glob_q;
        synth_d  = synth_q;
        rdata_d  = 8'h00;
        rd_seg_d = 1'b0;
        retune_d = 1'b0;
        if (host_wr && host_addr == liu_pkg::OFS_GLOBAL) begin
            glob_d = host_wdata & liu_pkg::GLOBAL_MASK;  // [RULE17]
        end else if (host_wr && host_addr == liu_pkg::OFS_SYNTH) begin
            synth_d = host_wdata;
            // Clock group change retunes the PLL feeding host timing
            retune_d = ((host_wdata ^ synth_q) & liu_pkg::SYNTH_CLK_GRP) != 8'h00;  // [RULE12]
        end
        if (host_rd) begin
            if (seg_hit(host_addr)) begin
                rd_seg_d = 1'b1;
            end else if (host_addr == liu_pkg::OFS_GLOBAL) begin
                rdata_d = glob_q;
            end else if (host_addr == liu_pkg::OFS_SYNTH) begin
                rdata_d = synth_q;
            end else begin
                rdata_d = 8'h00;
            end
        end
    end

    // Host registers only see srst, never the soft reset
    always_ff @(posedge clock) begin
        if (srst) begin
            glob_q   <= liu_pkg::GLOBAL_RST;
            synth_q  <= liu_pkg::SYNTH_RST;
            rdata_q  <= 8'h00;
            rd_seg_q <= 1'b0;
            retune_q <= 1'b0;
        end else begin
            glob_q   <= glob_d;  // [RULE10]
            synth_q  <= synth_d;
            rdata_q  <= rdata_d;
            rd_seg_q <= rd_seg_d;
            retune_q <= retune_d;
        end
    end

    assign host_rdata            = rd_seg_q ? {1'b0, seg.rdata} : rdata_q;  // [RULE17]
    assign rail_mode_select      = glob_q[liu_pkg::GB_RAIL];     // [RULE3]
    assign auto_ones_on_los      = glob_q[liu_pkg::GB_AUTO1];    // [RULE4]
    assign rx_out_edge_select    = glob_q[liu_pkg::GB_RXEDGE];   // [RULE5]
    assign tx_sample_edge_select = glob_q[liu_pkg::GB_TXEDGE];   // [RULE6]
    assign line_data_polarity    = glob_q[liu_pkg::GB_POL];      // [RULE7]
    assign global_irq_enable     = glob_q[liu_pkg::GB_IRQEN];    // [RULE8]
    assign soft_reset_bit        = glob_q[liu_pkg::GB_SRST];
    // All clocks come from one synthesizer setting
    assign synth_source_select   = synth_q[liu_pkg::SB_SRC_HI:liu_pkg::SB_SRC_LO];  // [RULE11]
    assign synth_rate_select     = synth_q[liu_pkg::SB_RATE];    // [RULE15]
    assign synth_retune          = retune_q;

    // ------------------------------------------------------------------
    // Soft reset hold timer; short pulses are filtered out
    // ------------------------------------------------------------------
    logic [8:0] hold_q, hold_d;
    logic       core_q, core_d;

    always_comb begin
        hold_d = soft_reset_bit ? hold_q : 9'h000;
        core_d = 1'b0;
        if (soft_reset_bit && hold_q != liu_pkg::SRST_W'(liu_pkg::SRST_CYCLES)) begin
            hold_d = hold_q + 9'h001;
        end
        if (soft_reset_bit && hold_q == liu_pkg::SRST_W'(liu_pkg::SRST_CYCLES)) begin
            core_d = 1'b1;  // [RULE9]
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            hold_q <= 9'h000;
            core_q <= 1'b0;
        end else begin
            hold_q <= hold_d;
            core_q <= core_d;
        end
    end
    assign core_reset = srst | core_q;  // [RULE10]

    // ------------------------------------------------------------------
    // Per-channel line data, loss of signal and interrupts
    // ------------------------------------------------------------------
    logic [12:0] zrun_q [liu_pkg::NCH];
    logic [12:0] zrun_d [liu_pkg::NCH];
    logic [12:0] los_lim;
    logic [3:0]  los_q, los_d, tp_q, tp_d, tn_q, tn_d, rp_q, rp_d, rn_q, rn_d, irq_q, irq_d;
    logic [3:0]  pol;

    always_comb begin
        // Threshold tracks the synthesized line rate unless ext_los_en selects the extended run
        los_lim = ext_los_en ? liu_pkg::LOS_EXT_BITS :
                  (synth_rate_select ? liu_pkg::LOS_T1_BITS : liu_pkg::LOS_E1_BITS);  // [RULE16]
        pol   = {4{line_data_polarity}};
        los_d = los_q;
        for (int i = 0; i < liu_pkg::NCH; i++) begin
            zrun_d[i] = zrun_q[i];
            if (rx_bit_valid[i]) begin
                // Line side is active high; polarity only applies at the data pins
                if (rx_pos_in[i] | rx_neg_in[i]) begin
                    zrun_d[i] = 13'h0000;
                    los_d[i]  = 1'b0;
                end else if (zrun_q[i] < los_lim) begin  // Saturates even after a limit drop
                    zrun_d[i] = zrun_q[i] + 13'h0001;
                end
                if (zrun_d[i] >= los_lim) begin
                    los_d[i] = 1'b1;  // [RULE16]
                end
            end
        end
        // Inputs taken to internal active high, forced ones on loss
        tp_d = (tx_positive_in ^ pol) | (los_q & {4{auto_ones_on_los}});  // [RULE4] [RULE7]
        tn_d = rail_mode_select ? 4'h0 :
               ((tx_negative_in ^ pol) & ~(los_q & {4{auto_ones_on_los}}));  // [RULE3] [RULE7]
        rp_d = rx_pos_in ^ pol;  // [RULE7]
        rn_d = rail_mode_select ? 4'h0 : (rx_neg_in ^ pol);  // [RULE3] [RULE7]
        irq_d = chan_irq_req & {4{global_irq_enable}};  // [RULE8]
    end

    always_ff @(posedge clock) begin
        if (core_reset) begin
            for (int i = 0; i < liu_pkg::NCH; i++) begin
                zrun_q[i] <= 13'h0000;
            end
            los_q <= 4'h0;
            tp_q  <= 4'h0;
            tn_q  <= 4'h0;
            rp_q  <= 4'h0;
            rn_q  <= 4'h0;
            irq_q <= 4'h0;
        end else begin
            zrun_q <= zrun_d;
            los_q  <= los_d;
            tp_q   <= tp_d;
            tn_q   <= tn_d;
            rp_q   <= rp_d;
            rn_q   <= rn_d;
            irq_q  <= irq_d;
        end
    end
    assign tx_pos_line       = tp_q;
    assign tx_neg_line       = tn_q;
    assign rx_pos_out        = rp_q;
    assign rx_neg_out        = rn_q;
    assign rx_loss_of_signal = los_q;
    assign chan_irq          = irq_q;

    // ------------------------------------------------------------------
    // User pulse segment sequencer: eight slots per master period
    // ------------------------------------------------------------------
    logic [2:0]  sg_q, sg_d;
    logic [27:0] amp_q, amp_d;

    always_comb begin
        sg_d  = arb_pulse_en ? sg_q + 3'h1 : 3'h0;  // [RULE2]
        amp_d = 28'h000_0000;
        if (arb_pulse_en && sg_d == liu_pkg::SEG_LAST) begin
            amp_d = seg.amp;  // [RULE1] [RULE2]
        end
    end

    always_ff @(posedge clock) begin
        if (core_reset) begin
            sg_q  <= 3'h0;
            amp_q <= 28'h000_0000;
        end else begin
            sg_q  <= sg_d;
            amp_q <= amp_d;
        end
    end
    assign pulse_segment = sg_q;
    assign pulse_amp     = amp_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    glob_write_a: assert property (host_wr && host_addr == liu_pkg::OFS_GLOBAL |=> // [RULE3]
        glob_q == ($past(host_wdata) & liu_pkg::GLOBAL_MASK)) else $error("global write lost");
    reserved_zero_a: assert property (!glob_q[2] && !(rd_seg_q && host_rdata[7]))  // [RULE17]
        else $error("reserved bit set");
    srst_short_a: assert property (!soft_reset_bit ##1 soft_reset_bit[*8] |-> !core_q)  // [RULE9]
        else $error("soft reset too early");
    srst_hold_a: assert property ($rose(core_q) |-> hold_q == 9'd400 && soft_reset_bit)  // [RULE9]
        else $error("soft reset timing wrong");
    regs_kept_a: assert property (core_q && !host_wr |=> $stable(glob_q) && $stable(synth_q))  // [RULE10]
        else $error("registers lost in soft reset");
    irq_gate_a: assert property (!global_irq_enable ##1 !global_irq_enable |-> chan_irq == 4'h0)  // [RULE8]
        else $error("interrupt leaked");
    auto_ones_a: assert property (auto_ones_on_los && los_q[0] && !line_data_polarity  // [RULE4]
        && !core_reset |=> tx_pos_line[0]) else $error("all ones missing");
    single_rail_a: assert property (rail_mode_select |=> tx_neg_line == 4'h0 || $past(core_q)  // [RULE3]
        || !rail_mode_select) else $error("negative rail active");
    seg_slot_a: assert property (pulse_amp != 28'h000_0000 |-> pulse_segment == liu_pkg::SEG_LAST)  // [RULE2]
        else $error("amplitude outside last slot");
    retune_a: assert property (synth_retune |-> $changed(synth_q[6:3]))  // [RULE12]
        else $error("spurious retune");

    los_cover_c:    cover property ($rose(rx_loss_of_signal[0]));
    srst_cover_c:   cover property ($rose(core_q));
    pulse_cover_c:  cover property (pulse_segment == liu_pkg::SEG_LAST && arb_pulse_en);
    retune_cover_c: cover property (synth_retune);
endmodule : liu_global_control_regs

`default_nettype wire

/* File: rtl/liu_pkg.sv */
// Package of offsets, field positions and timing for the line unit control bank
// ----------------------------------------------------------------------------
// Summary of operation
// [RULE1] Segment-eight register holds a seven-bit sign-magnitude amplitude, sign on top.
// [RULE2] User pulse splits into eight segments; eighth amplitude drives the last one.
// [RULE3] Global bit 7 one selects single-rail for all channels, zero dual-rail.
// [RULE4] Global bit 6 one sends all ones on a channel that lost signal.
// [RULE5] Global bit 5 one updates receive data on falling recovered clock edge.
// [RULE6] Global bit 4 zero samples transmit inputs on falling transmit clock edge.
// [RULE7] Global bit 3 one makes transmit input and receive output active low.
// [RULE8] Global bit 1 gates interrupt generation of every channel.
// [RULE9] Soft reset starts only after bit 0 stays one beyond 10 us.
// [RULE10] During soft reset all internal logic resets but host registers keep contents.
// [RULE11] All internal clock references come from the one synthesized master clock.
// [RULE12] Host timing follows the synthesizer, retuned when its clock bits change.
// [RULE13] Host rewrites synthesizer bits 7 and 2..0 unchanged when changing 6..3.
// [RULE14] Host changes both synthesizer groups in two separate writes, any order.
// [RULE15] Rate bit zero selects E1 master clock, one selects T1/J1.
// [RULE16] Loss of signal after 175, 32 or 4096 consecutive zeros.
// [RULE17] Reserved segment bit 7 and global bit 2 read zero, no effect.
// ----------------------------------------------------------------------------
`default_nettype none

package liu_pkg;
    localparam int           ADDR_W        = 7;
    localparam int           NCH           = 4;
    localparam int           AMP_W         = 7;
    // Register offsets
    localparam logic [6:0]   OFS_SEG8_CH0  = 7'h0f;
    localparam logic [6:0]   OFS_SEG8_CH1  = 7'h1f;
    localparam logic [6:0]   OFS_SEG8_CH2  = 7'h2f;
    localparam logic [6:0]   OFS_SEG8_CH3  = 7'h3f;
    localparam logic [6:0]   OFS_GLOBAL    = 7'h40;
    localparam logic [6:0]   OFS_SYNTH     = 7'h41;
    // Reset values
    localparam logic [7:0]   GLOBAL_RST    = 8'h00;
    localparam logic [7:0]   SYNTH_RST     = 8'h00;
    localparam logic [6:0]   SEG_RST       = 7'h00;
    // Global field positions
    localparam int           GB_RAIL       = 7;
    localparam int           GB_AUTO1      = 6;
    localparam int           GB_RXEDGE     = 5;
    localparam int           GB_TXEDGE     = 4;
    localparam int           GB_POL        = 3;
    localparam int           GB_IRQEN      = 1;
    localparam int           GB_SRST       = 0;
    localparam logic [7:0]   GLOBAL_MASK   = 8'hfb;
    // Synthesizer fields: clock group D6..D3, other group D7, D2..D0
    localparam int           SB_SRC_HI     = 6;
    localparam int           SB_SRC_LO     = 4;
    localparam int           SB_RATE       = 3;
    localparam logic [7:0]   SYNTH_CLK_GRP = 8'h78;
    // Pulse segments
    localparam logic [2:0]   SEG_LAST      = 3'h7;
    // Loss-of-signal zero runs
    localparam int           LOS_W         = 13;
    localparam logic [12:0]  LOS_T1_BITS   = 13'd175;
    localparam logic [12:0]  LOS_E1_BITS   = 13'd32;
    localparam logic [12:0]  LOS_EXT_BITS  = 13'd4096;
    // Soft reset hold time
    localparam int           CLK_PERIOD_NS = 25;
    localparam int           SRST_TIME_NS  = 10000;
    localparam int           SRST_CYCLES   = (SRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int           SRST_W        = 9;
endpackage : liu_pkg

`default_nettype wire

/* File: rtl/liu_seg_if.sv */
// Interface between control bank and the segment amplitude store
`default_nettype none

interface liu_seg_if;
    logic                                   wr;
    logic [1:0]                             wr_idx;
    logic [liu_pkg::AMP_W-1:0]              wdata;
    logic [1:0]                             rd_idx;
    logic [liu_pkg::AMP_W-1:0]              rdata;
    logic [liu_pkg::NCH*liu_pkg::AMP_W-1:0] amp;

    modport mem (input wr, wr_idx, wdata, rd_idx, output rdata, amp);
    modport ctl (output wr, wr_idx, wdata, rd_idx, input rdata, amp);
endinterface : liu_seg_if

`default_nettype wire

/* File: rtl/liu_seg_mem.sv */
// Store of the four channel segment-eight amplitudes
`default_nettype none

module liu_seg_mem (
    input  wire logic clock,
    input  wire logic srst,
    liu_seg_if.mem    port
);
    logic [liu_pkg::AMP_W-1:0] mem_q [liu_pkg::NCH];
    logic [liu_pkg::AMP_W-1:0] mem_d [liu_pkg::NCH];
    logic [liu_pkg::AMP_W-1:0] rd_q;
    logic [liu_pkg::AMP_W-1:0] rd_d;

    // ------------------------------------------------------------------
    // Next values; only host reset clears, soft reset keeps contents
    // ------------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < liu_pkg::NCH; i++) begin
            mem_d[i] = mem_q[i];
        end
        if (port.wr) begin
            mem_d[port.wr_idx] = port.wdata;  // [RULE1] [RULE10]
        end
        rd_d = mem_q[port.rd_idx];
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            for (int i = 0; i < liu_pkg::NCH; i++) begin
                mem_q[i] <= liu_pkg::SEG_RST;
            end
            rd_q <= liu_pkg::SEG_RST;
        end else begin
            mem_q <= mem_d;
            rd_q  <= rd_d;
        end
    end

    // Parallel view for the pulse generator
    always_comb begin
        port.amp = '0;
        for (int i = 0; i < liu_pkg::NCH; i++) begin
            port.amp[i*liu_pkg::AMP_W +: liu_pkg::AMP_W] = mem_q[i];
        end
    end
    assign port.rdata = rd_q;
endmodule : liu_seg_mem

`default_nettype wire

/* File: testbench/liu_global_control_regs_tb_top.sv */
// Self-checking bench for the line unit global control bank
`default_nettype none

module liu_global_control_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [6:0] a;
        logic [7:0] w;
        logic [7:0] e;
    } liu_row_s;

    // Rows: address, written byte, byte read back
    localparam liu_row_s ROWS [7] = '{
        '{7'h0f, 8'hff, 8'h7f}, '{7'h1f, 8'h55, 8'h55}, '{7'h2f, 8'hc0, 8'h40},
        '{7'h3f, 8'h81, 8'h01}, '{7'h40, 8'h04, 8'h00}, '{7'h41, 8'h85, 8'h85},
        '{7'h10, 8'hff, 8'h00}};

    logic        clock = 1'b0;
    logic        srst  = 1'b1;
    logic [6:0]  host_addr;
    logic [7:0]  host_wdata, host_rdata, rd;
    logic        host_wr, host_rd, arb_pulse_en = 1'b0, ext_los_en = 1'b0;
    logic [3:0]  tx_positive_in = 4'h0, tx_negative_in = 4'h0, rx_pos_in = 4'h0;
    logic [3:0]  rx_neg_in = 4'h0, rx_bit_valid = 4'h0, chan_irq_req = 4'h0;
    logic [3:0]  tx_pos_line, tx_neg_line, rx_pos_out, rx_neg_out, chan_irq, rx_loss_of_signal;
    logic        rail_mode_select, auto_ones_on_los, rx_out_edge_select, tx_sample_edge_select;
    logic        line_data_polarity, global_irq_enable, soft_reset_bit, core_reset;
    logic        synth_rate_select, synth_retune;
    logic [2:0]  synth_source_select, pulse_segment;
    logic [27:0] pulse_amp;
    int          mismatches = 0, n_compared = 0, retunes = 0, k;

    liu_global_control_regs dut (
        .clock(clock), .srst(srst), .host_addr(host_addr), .host_wdata(host_wdata),
        .host_wr(host_wr), .host_rd(host_rd), .host_rdata(host_rdata),
        .tx_positive_in(tx_positive_in), .tx_negative_in(tx_negative_in),
        .rx_pos_in(rx_pos_in), .rx_neg_in(rx_neg_in), .rx_bit_valid(rx_bit_valid),
        .chan_irq_req(chan_irq_req), .arb_pulse_en(arb_pulse_en), .ext_los_en(ext_los_en),
        .tx_pos_line(tx_pos_line), .tx_neg_line(tx_neg_line), .rx_pos_out(rx_pos_out),
        .rx_neg_out(rx_neg_out), .chan_irq(chan_irq), .rx_loss_of_signal(rx_loss_of_signal),
        .rail_mode_select(rail_mode_select), .auto_ones_on_los(auto_ones_on_los),
        .rx_out_edge_select(rx_out_edge_select), .tx_sample_edge_select(tx_sample_edge_select),
        .line_data_polarity(line_data_polarity), .global_irq_enable(global_irq_enable),
        .soft_reset_bit(soft_reset_bit), .core_reset(core_reset),
        .synth_source_select(synth_source_select), .synth_rate_select(synth_rate_select),
        .synth_retune(synth_retune), .pulse_segment(pulse_segment), .pulse_amp(pulse_amp));

    liu_host_model host (
        .host_addr(host_addr), .host_wdata(host_wdata), .host_wr(host_wr),
        .host_rd(host_rd), .host_rdata(host_rdata), .clock(clock));

    // ------------------------------------------------------------------
    // Clock, watchdog and helpers
    // ------------------------------------------------------------------
    initial begin
        forever #12.5 clock = ~clock;
    end

    // Whole run needs a few thousand cycles; twenty thousand is ample
    initial begin
        #(25 * 20000);
        mismatches++;
        print_verdict();
    end

    always @(posedge clock) begin
        if (synth_retune === 1'b1) retunes++;
    end

    task automatic check(input string what, input logic [27:0] exp, input logic [27:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(negedge clock);
    endtask

    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        cycles(12);
        srst = 1'b0;
        foreach (ROWS[i]) begin
            host.read_reg(ROWS[i].a, rd);
            check("reset value", 28'h0, {20'h0, rd});
        end
        foreach (ROWS[i]) begin
            host.write_reg(ROWS[i].a, ROWS[i].w);
            host.read_reg(ROWS[i].a, rd);
            check("readback", {20'h0, ROWS[i].e}, {20'h0, rd});
        end
        // Each global bit alone reaches only its own export
        foreach (ROWS[i]) begin
            k = (i < 5) ? 7 - i : 6 - i;
            host.write_reg(liu_pkg::OFS_GLOBAL, 8'h01 << k);
            cycles(1);
            check("global exports", {21'h0, 7'h40 >> i}, {21'h0, rail_mode_select,
                auto_ones_on_los, rx_out_edge_select, tx_sample_edge_select,
                line_data_polarity, global_irq_enable, soft_reset_bit});
            if (k == 0) host.write_reg(liu_pkg::OFS_GLOBAL, 8'h00);
        end
        // Interrupt gating, both ways
        chan_irq_req = 4'ha;
        cycles(2);
        check("irq gated", 28'h0, {24'h0, chan_irq});
        host.write_reg(liu_pkg::OFS_GLOBAL, 8'h02);
        cycles(2);
        check("irq passed", 28'ha, {24'h0, chan_irq});
        // Active-low data and single rail
        tx_positive_in = 4'h3;
        tx_negative_in = 4'h5;
        rx_pos_in = 4'h6;
        rx_neg_in = 4'h9;
        host.write_reg(liu_pkg::OFS_GLOBAL, 8'h08);
        cycles(2);
        check("tx pos inverted", 28'hc, {24'h0, tx_pos_line});
        check("rx pos inverted", 28'h9, {24'h0, rx_pos_out});
        host.write_reg(liu_pkg::OFS_GLOBAL, 8'h80);
        cycles(2);
        check("tx pos high", 28'h3, {24'h0, tx_pos_line});
        check("single rail", 28'h0, {20'h0, tx_neg_line, rx_neg_out});
        // Loss of signal after exactly 32 zero bits, then all ones
        host.write_reg(liu_pkg::OFS_GLOBAL, 8'h40);
        rx_pos_in = 4'h0;
        rx_neg_in = 4'h0;
        tx_positive_in = 4'h0;
        for (int n = 1; n <= 32; n++) begin
            @(negedge clock) rx_bit_valid = 4'hf;
            @(negedge clock) rx_bit_valid = 4'h0;
            cycles(1);
            check("loss flag", (n == 32) ? 28'hf : 28'h0, {24'h0, rx_loss_of_signal});
        end
        check("all ones", 28'h0f, {20'h0, tx_neg_line, tx_pos_line});
        // Short soft reset pulse is ignored, long one clears channel state
        host.write_reg(liu_pkg::OFS_GLOBAL, 8'h41);
        cycles(100);
        host.write_reg(liu_pkg::OFS_GLOBAL, 8'h40);
        check("short soft reset", 28'hf, {23'h0, core_reset, rx_loss_of_signal});
        host.write_reg(liu_pkg::OFS_GLOBAL, 8'h41); // held beyond 10 us
        cycles(390);
        check("soft reset early", 28'h0, {27'h0, core_reset});
        k = 0;
        while (core_reset !== 1'b1 && k < 30) begin
            cycles(1);
            k++;
        end
        cycles(2);
        check("soft reset taken", 28'h10, {23'h0, core_reset, rx_loss_of_signal});
        host.read_reg(7'h1f, rd);
        check("register kept", 28'h55, {20'h0, rd});
        host.write_reg(liu_pkg::OFS_GLOBAL, 8'h00);
        cycles(2);
        check("soft reset end", 28'h0, {27'h0, core_reset});
        // Eighth segment carries the stored amplitudes, the following first segment none
        arb_pulse_en = 1'b1;
        k = 0;
        while (pulse_segment !== 3'h7 && k < 20) begin
            cycles(1);
            k++;
        end
        check("segment eight", {7'h01, 7'h40, 7'h55, 7'h7f}, pulse_amp);
        cycles(1);
        check("segment one", 28'h0, pulse_amp);
        // Rate and source change, retune only for the clock group
        host.synth_write(8'h2d);
        cycles(1);
        check("synth fields", 28'h5, {24'h0, synth_source_select, synth_rate_select});
        check("retunes", 28'h1, 28'(retunes));
        // Rate bit now picks T1: loss after 175 zeros, then the extended 4096 run
        rx_bit_valid = 4'hf;
        cycles(174);
        check("t1 loss early", 28'h0, {24'h0, rx_loss_of_signal});
        cycles(1);
        check("t1 loss", 28'hf, {24'h0, rx_loss_of_signal});
        rx_pos_in = 4'hf;
        cycles(1);
        rx_pos_in = 4'h0;
        ext_los_en = 1'b1;
        check("loss cleared", 28'h0, {24'h0, rx_loss_of_signal});
        cycles(4095);
        check("ext loss early", 28'h0, {24'h0, rx_loss_of_signal});
        cycles(1);
        check("ext loss", 28'hf, {24'h0, rx_loss_of_signal});
        print_verdict();
    end
endmodule // liu_global_control_regs_tb_top

`default_nettype wire

/* File: testbench/liu_host_model.sv */
// Host processor model driving the parallel register port of the line unit
`default_nettype none

module liu_host_model (
    output logic      [6:0] host_addr,
    output logic      [7:0] host_wdata,
    output logic            host_wr,
    output logic            host_rd,
    input  wire logic [7:0] host_rdata,
    input  wire logic       clock
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] synth_shadow = 8'h00; // Last value put in the synthesizer register

    initial begin
        host_addr  = 7'h00;
        host_wdata = 8'h00;
        host_wr    = 1'b0;
        host_rd    = 1'b0;
    end

    // One write; released lines show the inverse of the last value
    task automatic write_reg(input logic [6:0] a, input logic [7:0] d);
        @(negedge clock);
        host_addr  = a;
        host_wdata = d;
        host_wr    = 1'b1;
        @(negedge clock);
        host_wr    = 1'b0;
        host_addr  = ~a;
        host_wdata = ~d;
        if (a == liu_pkg::OFS_SYNTH) synth_shadow = d;
    endtask

    // One read; data stands one cycle only, so take it at the release edge
    task automatic read_reg(input logic [6:0] a, output logic [7:0] d);
        @(negedge clock);
        host_addr = a;
        host_rd   = 1'b1;
        @(negedge clock);
        host_rd   = 1'b0;
        host_addr = ~a;
        d         = host_rdata;
    endtask

    // Clock group first, other bits second, so the PLL never sees both move
    task automatic synth_write(input logic [7:0] d);
        logic [7:0] mid;
        mid = (synth_shadow & ~liu_pkg::SYNTH_CLK_GRP) | (d & liu_pkg::SYNTH_CLK_GRP);
        if (mid != synth_shadow) write_reg(liu_pkg::OFS_SYNTH, mid);
        if (d != mid) write_reg(liu_pkg::OFS_SYNTH, d);
    endtask
endmodule // liu_host_model

`default_nettype wire
